// file: hw/fbph_device.sv
// Purpose: converter end, parameter channel and process-data channel
// Assumes: master keeps slots three to ten zero
// Notes: one parameter request in flight at a time
`timescale 1ns/1ns
module fbph_device import fbph_pkg::*; (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // link to master
   fbph_if.device link,
   // converter state
   input wire logic password_locked,
   input wire logic motor_running,
   input wire fbph_word_t drive_state_word,
   input wire fbph_word_t actual_frequency,
   input wire fbph_word_t monitor_values [MON_VALUES],
   // drive commands
   output logic run_cmd,
   output logic jog_cmd,
   output logic reverse_cmd,
   output logic stop_cmd,
   output logic estop_cmd,
   output logic fault_reset_cmd,
   output logic ramp_freeze,
   output fbph_word_t ref_frequency
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // flat word address of a group and index
   function automatic logic [GROUP_W+INDEX_W-1:0] param_addr(
      input logic [GROUP_W-1:0] grp, input logic [INDEX_W-1:0] idx);
      param_addr = {grp, idx};
   endfunction

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   fbph_word_t param_mem [PARAM_WORDS];   // parameter words
   fbph_state_t state_reg, state_next;    // request sequencer
   fbph_word_t task_reg;                  // taken request
   fbph_word_t index_reg;
   fbph_word_t value_reg;
   fbph_word_t rsp_task_reg;              // answer held for master
   fbph_word_t rsp_index_reg;
   fbph_word_t rsp_lo_reg;
   logic pzd_rsp_valid_reg;
   fbph_word_t pzd_rsp_reg [PZD_SLOTS];
   logic [7:0] drive_bits_reg;            // latched low command byte
   fbph_word_t ref_reg;

   // ----------------------------------------------------------------
   // request decode
   // ----------------------------------------------------------------
   wire [3:0] cmd = task_reg[TASK_CMD_MSB:TASK_CMD_LSB];
   // bit 11 is left out of every compare
   wire [10:0] grp_field = task_reg[TASK_GRP_MSB:0];
   wire [7:0] grp = grp_field[7:0];
   wire [7:0] idx = index_reg[15:INDEX_LSB];
   wire grp_ok = (grp_field < 11'(NUM_GROUPS));
   wire addr_ok = grp_ok && (idx < GROUP_LEN[grp[GROUP_W-1:0]]);
   wire [GROUP_W+INDEX_W-1:0] addr = param_addr(grp[GROUP_W-1:0], idx[INDEX_W-1:0]);
   wire is_read_only = (grp == HEATSINK_GROUP) && (idx == HEATSINK_INDEX);
   wire is_no_bus = (grp == RUN_DISPLAY_GROUP) && (idx == RUN_DISPLAY_INDEX);
   wire is_run_locked = (grp == RUN_LOCK_GROUP);
   wire is_skip_band = (grp == SKIP_BAND_GROUP) && (idx == SKIP_BAND_INDEX);
   wire [15:0] limit = is_skip_band ? SKIP_BAND_LIMIT : LIMIT_DEFAULT;
   wire cmd_read = (cmd == CMD_READ);
   wire cmd_write = (cmd == CMD_WRITE);
   wire cmd_none = (cmd == CMD_NONE);

   // ----------------------------------------------------------------
   // outcome of the taken request, first failure wins
   // ----------------------------------------------------------------
   logic fail;
   logic do_write;
   fbph_word_t err_code;
   always_comb begin
      fail = 1'b1;
      do_write = 1'b0;
      err_code = 16'h0000;
      if (cmd_none) begin
         // no task: plain zero answer
         fail = 1'b0;
      end else if (!cmd_read && !cmd_write) begin
         err_code = ERR_BAD_CMD;
      end else if (!addr_ok) begin
         err_code = ERR_BAD_ADDR;
      end else if (cmd_read) begin
         fail = 1'b0;
      end else if (password_locked) begin
         err_code = ERR_PASSWORD;
      end else if (is_read_only) begin
         err_code = ERR_READ_ONLY;
      end else if (is_no_bus) begin
         err_code = ERR_NO_BUS;
      end else if (motor_running && is_run_locked) begin
         err_code = ERR_RUNNING;
      end else if (value_reg > limit) begin
         err_code = ERR_RANGE;
      end else begin
         fail = 1'b0;
         do_write = 1'b1;
      end
   end

   // answer words built from the outcome
   wire [3:0] rsp_code = fail ? RSP_ERR : (cmd_none ? CMD_NONE : RSP_OK);
   wire [15:0] echo_task = {rsp_code, 1'b0, task_reg[TASK_GRP_MSB:0]};
   wire [15:0] rsp_lo = fail ? err_code :
                        cmd_write ? value_reg :
                        cmd_read ? param_mem[addr] : 16'h0000;

   // ----------------------------------------------------------------
   // sequencer: take, execute, hold answer until taken
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         FBPH_IDLE: begin
            if (link.req_valid) begin
               state_next = FBPH_EXEC;
            end
         end
         FBPH_EXEC: begin
            state_next = FBPH_RESP;
         end
         FBPH_RESP: begin
            // next request only after this answer is gone
            if (link.rsp_ready) begin
               state_next = FBPH_IDLE;
            end
         end
         default: begin
            state_next = FBPH_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= FBPH_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // request capture in idle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         task_reg <= 16'h0000;
         index_reg <= 16'h0000;
         value_reg <= 16'h0000;
      end else if (state_reg == FBPH_IDLE && link.req_valid) begin
         task_reg <= link.req_task;
         index_reg <= link.req_index;
         value_reg <= link.req_val_lo;
      end
   end

   // answer capture in execute
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rsp_task_reg <= 16'h0000;
         rsp_index_reg <= 16'h0000;
         rsp_lo_reg <= 16'h0000;
      end else if (state_reg == FBPH_EXEC) begin
         rsp_task_reg <= echo_task;
         rsp_index_reg <= index_reg;
         rsp_lo_reg <= rsp_lo;
      end
   end

   // parameter words, written only on a clean write
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < PARAM_WORDS; i++) begin
            param_mem[i] <= PARAM_RESET;
         end
      end else if (state_reg == FBPH_EXEC && do_write) begin
         param_mem[addr] <= value_reg;
      end
   end

   // link outputs for the parameter channel
   assign link.req_ready = (state_reg == FBPH_IDLE);
   assign link.rsp_valid = (state_reg == FBPH_RESP);
   assign link.rsp_task = rsp_task_reg;
   assign link.rsp_index = rsp_index_reg;
   assign link.rsp_val_hi = 16'h0000;
   assign link.rsp_val_lo = rsp_lo_reg;

   // ----------------------------------------------------------------
   // process data: command word and reference in
   // ----------------------------------------------------------------
   wire [15:0] cw_in = link.pzd_req_slot[0];
   // bit 7 set drops the whole command, reference included
   wire cw_take = link.pzd_req_valid && !cw_in[CW_IGNORE_BIT];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         drive_bits_reg <= 8'h00;
         ref_reg <= 16'h0000;
      end else if (cw_take) begin
         drive_bits_reg <= cw_in[7:0];
         ref_reg <= link.pzd_req_slot[1];
      end
   end

   // command bits out
   assign run_cmd = drive_bits_reg[CW_RUN_BIT];
   assign jog_cmd = drive_bits_reg[CW_JOG_BIT];
   assign reverse_cmd = drive_bits_reg[CW_REV_BIT];
   assign stop_cmd = drive_bits_reg[CW_STOP_BIT];
   assign estop_cmd = drive_bits_reg[CW_ESTOP_BIT];
   assign fault_reset_cmd = drive_bits_reg[CW_RESET_BIT];
   assign ramp_freeze = drive_bits_reg[CW_FREEZE_BIT];
   assign ref_frequency = ref_reg;

   // ----------------------------------------------------------------
   // process data: status, actual and monitors out
   // ----------------------------------------------------------------
   // each select word names two slots, low nibble first
   fbph_word_t mon_sel [PZD_SLOTS];
   assign mon_sel[0] = drive_state_word;
   assign mon_sel[1] = actual_frequency;
   genvar s;
   generate
      for (s = 2; s < PZD_SLOTS; s++) begin : g_mon
         localparam logic [3:0] SEL_IDX = MON_FIRST_INDEX + 4'((s - 2) / 2);
         wire [15:0] sel_word = param_mem[param_addr(MON_GROUP, SEL_IDX)];
         wire [3:0] pick = ((s % 2) == 0) ? sel_word[3:0] : sel_word[7:4];
         assign mon_sel[s] = monitor_values[pick];
      end
   endgenerate

   // answer one cycle after each request
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pzd_rsp_valid_reg <= 1'b0;
         for (int i = 0; i < PZD_SLOTS; i++) begin
            pzd_rsp_reg[i] <= 16'h0000;
         end
      end else begin
         pzd_rsp_valid_reg <= link.pzd_req_valid;
         if (link.pzd_req_valid) begin
            pzd_rsp_reg <= mon_sel;
         end
      end
   end

   assign link.pzd_rsp_valid = pzd_rsp_valid_reg;
   assign link.pzd_rsp_slot = pzd_rsp_reg;
endmodule

// file: hw/fbph_if.sv
// Purpose: link between fieldbus master end and converter end
// Assumes: both ends on core_clk
// Notes: parameter request and answer each carry valid and ready; process data carries valid only
`timescale 1ns/1ns
interface fbph_if import fbph_pkg::*; ();
   logic req_valid;                     // parameter request offered
   logic req_ready;                     // device can take it
   fbph_word_t req_task;                // task_word
   fbph_word_t req_index;               // index_word
   fbph_word_t req_val_hi;              // high value word
   fbph_word_t req_val_lo;              // low value word
   logic rsp_valid;                     // parameter answer offered
   logic rsp_ready;                     // master takes it
   fbph_word_t rsp_task;
   fbph_word_t rsp_index;
   fbph_word_t rsp_val_hi;
   fbph_word_t rsp_val_lo;
   logic pzd_req_valid;                 // process data request pulse
   fbph_word_t pzd_req_slot [PZD_SLOTS];
   logic pzd_rsp_valid;                 // process data answer pulse
   fbph_word_t pzd_rsp_slot [PZD_SLOTS];
   modport device (
      input req_valid, req_task, req_index, req_val_hi, req_val_lo,
      output req_ready,
      output rsp_valid, rsp_task, rsp_index, rsp_val_hi, rsp_val_lo,
      input rsp_ready,
      input pzd_req_valid, pzd_req_slot,
      output pzd_rsp_valid, pzd_rsp_slot
   );
   modport master (
      output req_valid, req_task, req_index, req_val_hi, req_val_lo,
      input req_ready,
      input rsp_valid, rsp_task, rsp_index, rsp_val_hi, rsp_val_lo,
      output rsp_ready,
      output pzd_req_valid, pzd_req_slot,
      input pzd_rsp_valid, pzd_rsp_slot
   );
endinterface

// file: hw/fbph_master.sv
// Purpose: master end, issues parameter and process-data requests
// Assumes: device answers every parameter request once
// Notes: user requests wait while one is in flight
`timescale 1ns/1ns
module fbph_master import fbph_pkg::*; (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // link to device
   fbph_if.master link,
   // parameter request from user
   input wire logic user_req_valid,
   output logic user_req_ready,
   input wire logic [3:0] user_cmd,
   input wire logic [7:0] user_group,
   input wire logic [7:0] user_index,
   input wire fbph_word_t user_value,
   // parameter answer to user
   output logic user_rsp_valid,
   output logic user_rsp_ok,
   output fbph_word_t user_rsp_value,
   // process data from user
   input wire logic user_pzd_send,
   input wire fbph_word_t drive_command_word,
   input wire fbph_word_t user_ref_freq,
   // process data back to user
   output logic user_pzd_valid,
   output fbph_word_t drive_state_word,
   output fbph_word_t actual_frequency,
   output fbph_word_t user_monitor [PZD_SLOTS-2]
);
   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   fbph_state_t state_reg, state_next;   // idle, offering, waiting
   fbph_word_t task_reg;
   fbph_word_t index_reg;
   fbph_word_t value_reg;
   logic rsp_valid_reg;
   logic rsp_ok_reg;
   fbph_word_t rsp_value_reg;
   logic pzd_valid_reg;
   fbph_word_t pzd_reg [PZD_SLOTS];
   fbph_word_t state_word_reg;
   fbph_word_t actual_reg;
   fbph_word_t mon_reg [PZD_SLOTS-2];

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         FBPH_IDLE: begin
            if (user_req_valid) begin
               state_next = FBPH_EXEC;
            end
         end
         FBPH_EXEC: begin
            if (link.req_ready) begin
               state_next = FBPH_RESP;
            end
         end
         FBPH_RESP: begin
            if (link.rsp_valid) begin
               state_next = FBPH_IDLE;
            end
         end
         default: begin
            state_next = FBPH_IDLE;
         end
      endcase
   end

   // state and request words; bit 11 always sent as zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= FBPH_IDLE;
         task_reg <= 16'h0000;
         index_reg <= 16'h0000;
         value_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         if (state_reg == FBPH_IDLE && user_req_valid) begin
            task_reg <= {user_cmd, 4'h0, user_group};
            index_reg <= {user_index, 8'h00};
            value_reg <= (user_cmd == CMD_WRITE) ? user_value : 16'h0000;
         end
      end
   end

   assign user_req_ready = (state_reg == FBPH_IDLE);
   assign link.req_valid = (state_reg == FBPH_EXEC);
   assign link.req_task = task_reg;
   assign link.req_index = index_reg;
   assign link.req_val_hi = 16'h0000;
   assign link.req_val_lo = value_reg;
   assign link.rsp_ready = (state_reg == FBPH_RESP);

   // answer capture, one-cycle pulse to user
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rsp_valid_reg <= 1'b0;
         rsp_ok_reg <= 1'b0;
         rsp_value_reg <= 16'h0000;
      end else begin
         rsp_valid_reg <= (state_reg == FBPH_RESP) && link.rsp_valid;
         if (state_reg == FBPH_RESP && link.rsp_valid) begin
            rsp_ok_reg <= (link.rsp_task[TASK_CMD_MSB:TASK_CMD_LSB] != RSP_ERR);
            rsp_value_reg <= link.rsp_val_lo;
         end
      end
   end

   assign user_rsp_valid = rsp_valid_reg;
   assign user_rsp_ok = rsp_ok_reg;
   assign user_rsp_value = rsp_value_reg;

   // ----------------------------------------------------------------
   // process data out: command, reference, zeros
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pzd_valid_reg <= 1'b0;
         for (int i = 0; i < PZD_SLOTS; i++) begin
            pzd_reg[i] <= 16'h0000;
         end
      end else begin
         pzd_valid_reg <= user_pzd_send;
         if (user_pzd_send) begin
            pzd_reg[0] <= drive_command_word;
            pzd_reg[1] <= user_ref_freq;
         end
      end
   end

   assign link.pzd_req_valid = pzd_valid_reg;
   assign link.pzd_req_slot = pzd_reg;

   // process data back: capture on each answer pulse
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         user_pzd_valid <= 1'b0;
         state_word_reg <= 16'h0000;
         actual_reg <= 16'h0000;
         for (int i = 0; i < PZD_SLOTS - 2; i++) begin
            mon_reg[i] <= 16'h0000;
         end
      end else begin
         user_pzd_valid <= link.pzd_rsp_valid;
         if (link.pzd_rsp_valid) begin
            state_word_reg <= link.pzd_rsp_slot[0];
            actual_reg <= link.pzd_rsp_slot[1];
            for (int i = 0; i < PZD_SLOTS - 2; i++) begin
               mon_reg[i] <= link.pzd_rsp_slot[i + 2];
            end
         end
      end
   end

   assign drive_state_word = state_word_reg;
   assign actual_frequency = actual_reg;
   assign user_monitor = mon_reg;
endmodule

// file: hw/fbph_pkg.sv
// Purpose: shared constants for the fieldbus parameter and process-data handler
// Assumes: one core clock, both ends on it
// Notes: parameter space is groups of up to 16 words of 16 bits
package fbph_pkg;
   // ----------------------------------------------------------------
   // parameter channel task word layout
   // ----------------------------------------------------------------
   localparam int TASK_CMD_MSB = 15;       // command nibble top
   localparam int TASK_CMD_LSB = 12;       // command nibble bottom
   localparam int TASK_RSVD_BIT = 11;      // don't-care bit on requests
   localparam int TASK_GRP_MSB = 10;       // group field top
   localparam int INDEX_LSB = 8;           // index byte bottom in index word
   localparam logic [3:0] CMD_NONE = 4'h0;  // no task
   localparam logic [3:0] CMD_READ = 4'h1;  // read request
   localparam logic [3:0] CMD_WRITE = 4'h2; // write request
   localparam logic [3:0] RSP_OK = 4'h1;    // success answer
   localparam logic [3:0] RSP_ERR = 4'h7;   // failure answer
   // ----------------------------------------------------------------
   // failure codes carried in the low value word
   // ----------------------------------------------------------------
   localparam logic [15:0] ERR_PASSWORD = 16'h0001;
   localparam logic [15:0] ERR_BAD_CMD = 16'h0002;
   localparam logic [15:0] ERR_BAD_ADDR = 16'h0003;
   localparam logic [15:0] ERR_RANGE = 16'h0004;
   localparam logic [15:0] ERR_RUNNING = 16'h0005;
   localparam logic [15:0] ERR_READ_ONLY = 16'h0006;
   localparam logic [15:0] ERR_NO_BUS = 16'h0007;
   // ----------------------------------------------------------------
   // parameter space
   // ----------------------------------------------------------------
   localparam int NUM_GROUPS = 8;          // groups held
   localparam int GROUP_W = 3;             // group address bits
   localparam int INDEX_W = 4;             // index address bits
   localparam int PARAM_WORDS = 128;       // groups times 16
   localparam logic [15:0] PARAM_RESET = 16'h0000;  // value after reset
   localparam logic [15:0] LIMIT_DEFAULT = 16'hFFFF;
   // valid index count per group
   localparam logic [7:0] GROUP_LEN [NUM_GROUPS] = '{
      8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h0C, 8'h10, 8'h08};
   localparam logic [7:0] HEATSINK_GROUP = 8'h00;   // heatsink_temp_param
   localparam logic [7:0] HEATSINK_INDEX = 8'h0C;
   localparam logic [7:0] RUN_DISPLAY_GROUP = 8'h00; // run_display_select_param
   localparam logic [7:0] RUN_DISPLAY_INDEX = 8'h08;
   localparam logic [7:0] SKIP_BAND_GROUP = 8'h05;  // skip_band_width_param
   localparam logic [7:0] SKIP_BAND_INDEX = 8'h06;
   localparam logic [15:0] SKIP_BAND_LIMIT = 16'h0FA0;
   localparam logic [7:0] RUN_LOCK_GROUP = 8'h05;   // frozen while running
   localparam logic [2:0] MON_GROUP = 3'h7;         // monitor_slot_select_param
   localparam logic [3:0] MON_FIRST_INDEX = 4'h4;   // four select words
   // ----------------------------------------------------------------
   // process data
   // ----------------------------------------------------------------
   localparam int PZD_SLOTS = 10;          // slots one to ten
   localparam int MON_VALUES = 16;         // selectable monitor values
   localparam int CW_RUN_BIT = 0;
   localparam int CW_JOG_BIT = 1;
   localparam int CW_REV_BIT = 2;
   localparam int CW_STOP_BIT = 3;
   localparam int CW_ESTOP_BIT = 4;
   localparam int CW_RESET_BIT = 5;
   localparam int CW_FREEZE_BIT = 6;
   localparam int CW_IGNORE_BIT = 7;
   // ----------------------------------------------------------------
   // shared types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FBPH_IDLE = 2'b00,
      FBPH_EXEC = 2'b01,
      FBPH_RESP = 2'b11
   } fbph_state_t;
   typedef logic [15:0] fbph_word_t;
endpackage

// file: verif/fbph_props.sv
// Purpose: link properties of the parameter and process-data channels
// Assumes: one clock, rst active high
// Notes: sits beside the interface joining both ends
`timescale 1ns/1ns
module fbph_props import fbph_pkg::*; (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // parameter channel
   input wire logic req_valid,
   input wire logic req_ready,
   input wire fbph_word_t req_task,
   input wire fbph_word_t req_index,
   input wire logic rsp_valid,
   input wire fbph_word_t rsp_task,
   input wire fbph_word_t rsp_index,
   input wire fbph_word_t rsp_val_hi,
   input wire fbph_word_t rsp_val_lo,
   // process data
   input wire logic pzd_req_valid,
   input wire logic pzd_rsp_valid
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // request taken, then exec cycle, then answer
   sequence s_take; req_valid && req_ready; endsequence
   sequence s_ans; !rsp_valid ##1 rsp_valid; endsequence
   property p_ans; s_take |=> s_ans; endproperty
   a_ans: assert property (p_ans) else $error("answer not two cycles after take");
   property p_busy; rsp_valid |-> !req_ready; endproperty
   a_busy: assert property (p_busy) else $error("request taken during answer");
   property p_hi; rsp_valid |-> rsp_val_hi == 16'h0000; endproperty
   a_hi: assert property (p_hi) else $error("high value word not zero");
   property p_nib; rsp_valid |-> rsp_task[15:12] inside {4'h0, 4'h1, 4'h7}; endproperty
   a_nib: assert property (p_nib) else $error("bad answer nibble");
   property p_b11; rsp_valid |-> !rsp_task[11]; endproperty
   a_b11: assert property (p_b11) else $error("answer bit 11 set");
   property p_echo; s_take |-> ##2 rsp_index == $past(req_index, 2); endproperty
   a_echo: assert property (p_echo) else $error("index not echoed");
   // illegal command nibble answers failure code 2
   property p_bad; s_take ##0 req_task[15:12] > 4'h2 |-> ##2
      rsp_task[15:12] == 4'h7 && rsp_val_lo == 16'h0002; endproperty
   a_bad: assert property (p_bad) else $error("illegal command not refused");
   property p_pzd; pzd_req_valid |=> pzd_rsp_valid; endproperty
   a_pzd: assert property (p_pzd) else $error("no process answer");
endmodule

// file: verif/testbench.sv
// Purpose: drives the master user side against the device end
// Assumes: 100 MHz core_clk, rst held 3 cycles
// Notes: converter inputs driven directly by the bench
`timescale 1ns/1ns
module testbench import fbph_pkg::*; ;
   logic core_clk = 1'b0, rst = 1'b1, pw = 1'b0, mot = 1'b0, u_vld = 1'b0, u_pzd = 1'b0;
   logic [3:0] u_cmd = 4'h0;
   logic [7:0] u_grp = 8'h00, u_idx = 8'h00;
   fbph_word_t u_val = 16'h0000, u_cw = 16'h0000, u_ref = 16'h0000;
   fbph_word_t d_sw = 16'h0180, d_act = 16'h1388, m_sw, m_act, u_rv, ref_f;
   fbph_word_t mv [MON_VALUES];
   fbph_word_t m_mon [PZD_SLOTS-2];
   wire logic [6:0] cmds;
   logic u_rdy, u_rvld, u_ok, p_vld;
   int error_cnt = 0, n_compared = 0;
   fbph_if i_fbph_if ();
   fbph_master i_fbph_master (.core_clk(core_clk), .rst(rst), .link(i_fbph_if),
      .user_req_valid(u_vld), .user_req_ready(u_rdy), .user_cmd(u_cmd), .user_group(u_grp),
      .user_index(u_idx), .user_value(u_val), .user_rsp_valid(u_rvld), .user_rsp_ok(u_ok),
      .user_rsp_value(u_rv), .user_pzd_send(u_pzd), .drive_command_word(u_cw),
      .user_ref_freq(u_ref), .user_pzd_valid(p_vld), .drive_state_word(m_sw),
      .actual_frequency(m_act), .user_monitor(m_mon));
   fbph_device i_fbph_device (.core_clk(core_clk), .rst(rst), .link(i_fbph_if),
      .password_locked(pw), .motor_running(mot), .drive_state_word(d_sw),
      .actual_frequency(d_act), .monitor_values(mv), .run_cmd(cmds[0]), .jog_cmd(cmds[1]),
      .reverse_cmd(cmds[2]), .stop_cmd(cmds[3]), .estop_cmd(cmds[4]),
      .fault_reset_cmd(cmds[5]), .ramp_freeze(cmds[6]), .ref_frequency(ref_f));
   fbph_props i_fbph_props (.core_clk(core_clk), .rst(rst), .req_valid(i_fbph_if.req_valid),
      .req_ready(i_fbph_if.req_ready), .req_task(i_fbph_if.req_task),
      .req_index(i_fbph_if.req_index), .rsp_valid(i_fbph_if.rsp_valid),
      .rsp_task(i_fbph_if.rsp_task), .rsp_index(i_fbph_if.rsp_index),
      .rsp_val_hi(i_fbph_if.rsp_val_hi), .rsp_val_lo(i_fbph_if.rsp_val_lo),
      .pzd_req_valid(i_fbph_if.pzd_req_valid), .pzd_rsp_valid(i_fbph_if.pzd_rsp_valid));
   // clock and watchdog
   initial forever #5 core_clk = ~core_clk;
   initial begin
      #100000;
      error_cnt++;
      report_and_stop;
   end
   task automatic chk(input fbph_word_t seen, input fbph_word_t exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one parameter request, held until taken, then its answer
   task automatic pk(input logic [3:0] c, input logic [7:0] g, i, input fbph_word_t v,
         input logic eok, input fbph_word_t ev);
      u_vld <= 1'b1;
      u_cmd <= c;
      u_grp <= g;
      u_idx <= i;
      u_val <= v;
      do @(posedge core_clk); while (u_rdy !== 1'b1);
      u_vld <= 1'b0;
      repeat (20) begin
         @(negedge core_clk);
         if (u_rvld === 1'b1) break;
      end
      chk({15'h0000, u_rvld}, 16'h0001);
      chk({15'h0000, u_ok}, {15'h0000, eok});
      chk(u_rv, ev);
      @(posedge core_clk);
   endtask
   // one process-data exchange
   task automatic pzd(input fbph_word_t cw, input fbph_word_t rf);
      u_pzd <= 1'b1;
      u_cw <= cw;
      u_ref <= rf;
      @(posedge core_clk);
      u_pzd <= 1'b0;
      repeat (20) begin
         @(negedge core_clk);
         if (p_vld === 1'b1) break;
      end
      chk({15'h0000, p_vld}, 16'h0001);
      @(posedge core_clk);
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      for (int k = 0; k < MON_VALUES; k++) mv[k] = 16'h0A00 + 16'(k);
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      pk(CMD_WRITE, 8'h05, 8'h06, 16'h0BB8, 1'b1, 16'h0BB8);
      pk(CMD_READ, 8'h05, 8'h06, 16'h0000, 1'b1, 16'h0BB8);
      pk(CMD_NONE, 8'h05, 8'h06, 16'h0000, 1'b1, 16'h0000);
      pk(CMD_READ, 8'h05, 8'h20, 16'h0000, 1'b0, ERR_BAD_ADDR);
      pk(CMD_READ, 8'h05, 8'h0C, 16'h0000, 1'b0, ERR_BAD_ADDR);
      pk(CMD_WRITE, 8'h05, 8'h06, 16'h1388, 1'b0, ERR_RANGE);
      pk(CMD_WRITE, 8'h05, 8'h06, 16'h0FA0, 1'b1, 16'h0FA0);
      pk(CMD_WRITE, 8'h05, 8'h06, 16'h0FA1, 1'b0, ERR_RANGE);
      for (int c = 3; c < 16; c++) pk(4'(c), 8'h05, 8'h06, 16'h0001, 1'b0, ERR_BAD_CMD);
      pw <= 1'b1;
      pk(CMD_WRITE, 8'h05, 8'h06, 16'h0001, 1'b0, ERR_PASSWORD);
      pw <= 1'b0;
      mot <= 1'b1;
      pk(CMD_WRITE, 8'h05, 8'h06, 16'h0001, 1'b0, ERR_RUNNING);
      mot <= 1'b0;
      pk(CMD_READ, 8'h05, 8'h06, 16'h0000, 1'b1, 16'h0FA0);
      pk(CMD_WRITE, 8'h00, 8'h0C, 16'h0001, 1'b0, ERR_READ_ONLY);
      pk(CMD_WRITE, 8'h00, 8'h08, 16'h0001, 1'b0, ERR_NO_BUS);
      pk(CMD_WRITE, 8'h07, 8'h04, 16'h0021, 1'b1, 16'h0021);
      pzd(16'h007F, 16'h1388);
      chk({9'h000, cmds}, 16'h007F);
      chk(ref_f, 16'h1388);
      chk(m_sw, d_sw);
      chk(m_act, d_act);
      chk(m_mon[0], mv[1]);
      chk(m_mon[1], mv[2]);
      chk(m_mon[7], mv[0]);
      pzd(16'h0080, 16'h4E20);
      chk({9'h000, cmds}, 16'h007F);
      chk(ref_f, 16'h1388);
      pzd(16'hFF00, 16'h0BB8);
      chk({9'h000, cmds}, 16'h0000);
      chk(ref_f, 16'h0BB8);
      report_and_stop;
   end
endmodule
